// ==== hw/branch_if_no_overflow_pkg.sv ====
// constants for the overflow-clear relative branch executor
// assumes one core clock, one clock edge per quarter phase of an instruction cycle
package ov_branch_pkg;
	// opcode upper byte, split in its two nibbles
	localparam logic [3:0] OPC_HI_NIB   = 4'he;
	localparam logic [3:0] OPC_LO_NIB   = 4'h5;
	localparam int         OPC_MSB      = 15;
	localparam int         OPC_LSB      = 8;
	localparam int         OFS_MSB      = 7;
	localparam int         OFS_LSB      = 0;
	localparam int         INSTR_W      = 16;
	localparam int         OFS_W        = 8;
	// quarter phases per instruction cycle
	localparam int         PHASES       = 4;
	localparam logic [1:0] PH_Q1        = 2'h0;
	localparam logic [1:0] PH_Q2        = 2'h1;
	localparam logic [1:0] PH_Q3        = 2'h2;
	localparam logic [1:0] PH_Q4        = 2'h3;
	// default program counter width and reset values
	localparam int         PC_W_DEF     = 21;
	localparam logic [7:0] OFS_RST      = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_NOP
	} seq_e;
endpackage : ov_branch_pkg

// ==== hw/branch_if_no_overflow_decode.sv ====
// opcode match and offset scaling for the overflow-clear branch
// assumes a 16-bit instruction word; purely combinational
`timescale 1ns/10ps
module ov_branch_decode
	import ov_branch_pkg::*;
#(
	parameter int PC_W = ov_branch_pkg::PC_W_DEF
)
(
	// instruction word
	input  wire logic [ov_branch_pkg::INSTR_W-1:0] i_instr,
	// decode results
	output logic                                   o_match,
	output logic [PC_W-1:0]                        o_disp
);
	import ov_branch_pkg::*;

	// the sign fill below needs room for the offset and its doubling bit
	if (PC_W < OFS_W + 2)
	begin : g_pc_w_check
		$error("PC_W too small for a doubled 8-bit offset");
	end

	// upper byte must read 1110 0101
	assign o_match = (i_instr[OPC_MSB -: 4] == OPC_HI_NIB)
		&& (i_instr[OPC_LSB +: 4] == OPC_LO_NIB);

	// two's complement word offset, sign-extended then doubled into bytes
	assign o_disp = {{(PC_W-OFS_W-1){i_instr[OFS_MSB]}}, i_instr[OFS_MSB:OFS_LSB], 1'b0};
endmodule // ov_branch_decode

// ==== hw/branch_not_overflow_exec.sv ====
// executor for the branch_if_no_overflow relative branch
// assumes the fetch unit offers one instruction with the already incremented
// program counter, and that the overflow flag is a steady level from the status register
`timescale 1ns/10ps
module branch_not_overflow_exec
	import ov_branch_pkg::*;
#(
	parameter int PC_W = ov_branch_pkg::PC_W_DEF
)
(
	// clock and reset
	input  wire logic                              I_MCLK,
	input  wire logic                              I_ARST_N,
	// instruction offered by fetch
	input  wire logic                              I_START,
	input  wire logic [ov_branch_pkg::INSTR_W-1:0] I_INSTR,
	input  wire logic [PC_W-1:0]                   I_PC,
	// status flag, read only
	input  wire logic                              I_OV,
	// handshake and progress
	output logic                                   O_READY,
	output logic                                   O_BUSY,
	output logic                                   O_NOP,
	output logic                                   O_DONE,
	// program counter write
	output logic                                   O_PC_WE,
	output logic [PC_W-1:0]                        O_PC_NEXT
);
	import ov_branch_pkg::*;

	// refuse widths the offset cannot fit in, at elaboration
	if (PC_W < OFS_W + 2)
	begin : g_pc_w_check
		$error("PC_W too small for a doubled 8-bit offset");
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	seq_e                  state;
	logic [1:0]            phase;
	logic [INSTR_W-1:0]    instr;
	logic [PC_W-1:0]       pc_inc;
	logic                  match;
	logic [OFS_W-1:0]      offset;
	logic                  taken;
	logic [PC_W-1:0]       pc_next;
	logic                  dec_match;
	logic [PC_W-1:0]       dec_disp;
	logic                  accept;
	logic                  last_q;

	ov_branch_decode #(.PC_W(PC_W)) u_decode
	(
		.i_instr (instr),
		.o_match (dec_match),
		.o_disp  (dec_disp)
	);

	assign accept = I_START && (state == ST_IDLE);
	assign last_q = (phase == PH_Q4);

	////////////////////////////////////////////////////////////////////////////
	// sequencer: four phases per cycle, a foreign opcode leaves after Q1, one extra cycle only when taken

	always_ff @(posedge I_MCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			state <= ST_IDLE;
			phase <= PH_Q1;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (accept)
					begin
						state <= ST_EXEC;
						phase <= PH_Q1;
					end
				end
				ST_EXEC:
				begin
					// a foreign opcode is dropped at decode, nothing executes
					if (phase == PH_Q1 && !dec_match)
						state <= ST_IDLE;
					else if (last_q)
					begin
						state <= taken ? ST_NOP : ST_IDLE;
						phase <= PH_Q1;
					end
					else
						phase <= phase + 2'h1;
				end
				ST_NOP:
				begin
					// phase back to Q1 so idle never rests in Q4
					if (last_q)
					begin
						state <= ST_IDLE;
						phase <= PH_Q1;
					end
					else
						phase <= phase + 2'h1;
				end
				default:
				begin
					state <= ST_IDLE;
					phase <= PH_Q1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// capture of the offered word and incremented pc

	always_ff @(posedge I_MCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			instr  <= '0;
			pc_inc <= '0;
		end
		else if (accept)
		begin
			instr  <= I_INSTR;
			pc_inc <= I_PC;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// datapath per phase

	// Q1 decode, Q2 literal
	always_ff @(posedge I_MCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			match  <= 1'b0;
			offset <= OFS_RST;
		end
		else if (state == ST_EXEC)
		begin
			if (phase == PH_Q1)
				match <= dec_match;
			if (phase == PH_Q2)
				offset <= instr[OFS_MSB:OFS_LSB];
		end
		else if (state == ST_IDLE)
			match <= 1'b0;
	end

	// Q3 process: condition and target; flag sampled late so the preceding
	// instruction's overflow update has settled
	always_ff @(posedge I_MCLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			taken   <= 1'b0;
			pc_next <= '0;
		end
		else if (state == ST_EXEC && phase == PH_Q3)
		begin
			taken   <= match && !I_OV;
			pc_next <= pc_inc + dec_disp;
		end
		else if (state == ST_IDLE)
			taken <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; no flag output exists, so status is never written

	assign O_READY   = (state == ST_IDLE);
	assign O_BUSY    = (state != ST_IDLE);
	assign O_NOP     = (state == ST_NOP);
	assign O_PC_WE   = (state == ST_EXEC) && last_q && taken;
	assign O_PC_NEXT = pc_next;
	assign O_DONE    = last_q && ((state == ST_NOP) || (state == ST_EXEC && !taken));

	////////////////////////////////////////////////////////////////////////////
	// checks

	// write happens four edges after accept, only with overflow clear and a match
	pc_write_when_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		O_PC_WE |-> (!$past(I_OV, 1) && match))
		else $error("pc written although overflow set or no match");

	// target equals incremented pc plus doubled signed offset
	pc_target_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		O_PC_WE |-> (O_PC_NEXT == pc_inc + {{(PC_W-OFS_W-1){offset[OFS_W-1]}}, offset, 1'b0}))
		else $error("branch target wrong");

	// matching opcode always reaches Q2
	opcode_match_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		(accept && I_INSTR[OPC_MSB:OPC_LSB] == {OPC_HI_NIB, OPC_LO_NIB}) |=> ##1 O_BUSY)
		else $error("matching opcode not executed");

	// foreign opcode is dropped right after decode
	opcode_reject_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		(accept && I_INSTR[OPC_MSB:OPC_LSB] != {OPC_HI_NIB, OPC_LO_NIB}) |=> ##1 O_READY)
		else $error("foreign opcode executed");

	// untaken: done four edges after accept, taken: eight
	cycle_short_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		(accept && I_INSTR[OPC_MSB:OPC_LSB] == {OPC_HI_NIB, OPC_LO_NIB} ##3 I_OV)
		|=> O_DONE && !O_PC_WE ##1 O_READY)
		else $error("untaken branch not one cycle");

	cycle_long_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		O_PC_WE |=> O_NOP [*3] ##1 (O_NOP && O_DONE) ##1 O_READY)
		else $error("taken branch not two cycles");

	// write only in the Q4 phase of the executing cycle
	write_phase_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		O_PC_WE |-> $past(state == ST_EXEC && phase == PH_Q3))
		else $error("pc written outside Q4");

	// never a write in the nop cycle or while idle
	no_stray_write_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		(O_NOP || O_READY) |-> !O_PC_WE)
		else $error("pc written in nop or idle");

	// overflow set at the Q3 edge means no write in the following Q4
	untaken_no_write_a: assert property (@(posedge I_MCLK) disable iff (!I_ARST_N)
		($past(state == ST_EXEC && phase == PH_Q3) && $past(I_OV)) |-> !O_PC_WE)
		else $error("pc written although branch not taken");
endmodule // branch_not_overflow_exec

// ==== tb/fetch_model.sv ====
// fetch side model: offers one word with its incremented pc
// assumes the executor samples on the rising edge
`timescale 1ns/10ps
module fetch_model
#(
	parameter int PC_W = 21
)
(
	// clock
	input  wire logic        i_clk,
	// offer to the executor
	output logic             o_start,
	output logic [15:0]      o_instr,
	output logic [PC_W-1:0]  o_pc
);
	///////////////////////////////////////////
	// quiet offer at time zero
	initial
	begin
		o_start = 1'b0;
		o_instr = 16'h0000;
		o_pc    = '0;
	end
	// drop the offer after one edge; words invert so no stale value shows
	always @(negedge i_clk)
	begin
		if (o_start)
		begin
			o_start <= 1'b0;
			o_instr <= ~o_instr;
			o_pc    <= ~o_pc;
		end
	end
	// one offer, set up off the sampling edge
	task automatic offer(input logic [15:0] w, input logic [PC_W-1:0] p);
		@(negedge i_clk);
		o_start <= 1'b1;
		o_instr <= w;
		o_pc    <= p;
	endtask
endmodule // fetch_model

// ==== tb/branch_not_overflow_exec_tb_top.sv ====
// bench for the overflow-clear branch executor
// assumes fetch_model beside it; assertions live in the design
`timescale 1ns/10ps
module branch_not_overflow_exec_tb_top;
	import ov_branch_pkg::*;
	localparam int PW = PC_W_DEF;
	logic          mclk = 1'b0, arst_n = 1'b0, ov = 1'b0, start;
	logic [15:0]   instr;
	logic [PW-1:0] pc, pc_next, seen_pc;
	logic          ready, busy, nop, done, pc_we;
	int            errors = 0, check_count = 0, cycles = 0;
	int            we_c, done_c, rdy_c, nops, bz;
	// word, pc, overflow, done cycle, pc write cycle, ready cycle
	typedef struct packed {logic [15:0] w; logic [PW-1:0] p; logic o; int d, we, r;} row_s;
	row_s rows[6] = '{
		'{16'he57f, 21'h000100, 1'b0, 8, 4, 9},
		'{16'he580, 21'h000100, 1'b0, 8, 4, 9},
		'{16'he5ff, 21'h000000, 1'b0, 8, 4, 9},
		'{16'he510, 21'h001234, 1'b1, 4, 0, 5},
		'{16'he710, 21'h000200, 1'b0, 0, 0, 2},
		'{16'h6510, 21'h000200, 1'b0, 0, 0, 2}};
	///////////////////////////////////////////
	fetch_model #(.PC_W(PW)) i_fetch_model (.i_clk(mclk), .o_start(start), .o_instr(instr),
		.o_pc(pc));
	branch_not_overflow_exec #(.PC_W(PW)) i_branch_not_overflow_exec (.I_MCLK(mclk),
		.I_ARST_N(arst_n), .I_START(start), .I_INSTR(instr), .I_PC(pc), .I_OV(ov),
		.O_READY(ready), .O_BUSY(busy), .O_NOP(nop), .O_DONE(done), .O_PC_WE(pc_we),
		.O_PC_NEXT(pc_next));
	// 100 MHz clock
	initial
		forever #5 mclk = ~mclk;
	// hang guard, far above the roughly 100 cycles needed
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles > 1000)
		begin
			errors++;
			stop_test();
		end
	end
	///////////////////////////////////////////
	function automatic logic [PW-1:0] tgt(input logic [PW-1:0] p, input logic [7:0] n);
		return p + {{(PW-9){n[7]}}, n, 1'b0};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// note in which cycle after the offer each output shows
	task automatic watch(input int n);
		we_c = 0;
		done_c = 0;
		rdy_c = 0;
		nops = 0;
		for (int c = 1; c <= n; c++)
		begin
			@(negedge mclk);
			if (c == 1)
				bz = (busy === 1'b1);
			if (pc_we === 1'b1)
			begin
				we_c = c;
				seen_pc = pc_next;
			end
			if (done === 1'b1)
				done_c = c;
			if (nop === 1'b1)
				nops++;
			if (rdy_c == 0 && ready === 1'b1)
				rdy_c = c;
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	///////////////////////////////////////////
	// reset, table rows, refused offer, reset in mid-branch
	initial
	begin
		repeat (8) @(negedge mclk);
		chk(ready, 1);
		chk(done, 0);
		chk(pc_we, 0);
		chk(pc_next, 0);
		arst_n = 1'b1;
		foreach (rows[i])
		begin
			ov = rows[i].o;
			i_fetch_model.offer(rows[i].w, rows[i].p);
			watch(10);
			chk(done_c, rows[i].d);
			chk(we_c, rows[i].we);
			chk(rdy_c, rows[i].r);
			chk(nops, rows[i].we ? 4 : 0);
			chk(bz, 1);
			if (rows[i].we != 0)
				chk(seen_pc, tgt(rows[i].p, rows[i].w[7:0]));
		end
		ov = 1'b0;
		i_fetch_model.offer(16'he502, 21'h000040);
		watch(2);
		i_fetch_model.offer(16'he5fe, 21'h000000);
		watch(6);
		chk(we_c, 1);
		chk(seen_pc, 21'h000044);
		chk(done_c, 5);
		i_fetch_model.offer(16'he501, 21'h000010);
		watch(6);
		chk(we_c, 4);
		arst_n = 1'b0;
		#1;
		chk(ready, 1);
		chk(nop, 0);
		chk(pc_next, 0);
		@(negedge mclk);
		arst_n = 1'b1;
		i_fetch_model.offer(16'he501, 21'h000010);
		watch(10);
		chk(we_c, 4);
		chk(seen_pc, 21'h000012);
		chk(done_c, 8);
		stop_test();
	end
endmodule // branch_not_overflow_exec_tb_top
